// *** hw/pts_time_core.sv ***
`timescale 1ns/1ps
module pts_time_core
  import pts_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [PTS_ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire pts_frame_t frame_i,
  output pts_stamp_t stamp_o,
  output logic pulse_output_o,
  output logic time_event_summary_o
);

  typedef struct packed {
    logic [PTS_CTRL_W-1:0] ctrl;
    logic [31:0] step;
    logic [31:0] addend;
    logic [31:0] acc;
    logic [31:0] sec;
    logic [31:0] subsec;
    logic [31:0] tgt_sec;
    logic [31:0] tgt_sub;
    logic [1:0] flags;
    logic [1:0] pend_start;
    logic pend_stop;
    pts_pg_state_t pg;
    logic train;
    logic [31:0] pcnt;
    logic [31:0] width;
    logic [31:0] period;
    logic pulse;
    pts_stamp_t stamp;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic summary;
  } pts_state_t;

  pts_state_t state_reg;
  pts_state_t state_next;

  ////////////////////////////////////////////////////////////////////////////
  // Combinational helpers

  logic ts_on;
  logic fine;
  logic [32:0] acc_sum;
  logic tick;
  logic [31:0] limit;
  logic [32:0] sub_sum;
  logic wrap;
  logic reached;
  logic fire;
  logic fire_int;
  logic fire_pulse;
  logic cmd_mode;
  logic [2:0] sel;
  logic enc_ok;
  logic ver_ok;
  logic msg_ok;
  logic ptp_ok;
  logic addr_ok;
  logic setup;
  logic access;
  logic wr;
  logic rd;
  logic mapped;
  logic [31:0] pcnt_inc;

  assign ts_on = state_reg.ctrl[PTS_CB_ENABLE];
  assign fine = state_reg.ctrl[PTS_CB_FINE];
  assign cmd_mode = state_reg.ctrl[PTS_CB_CMDMODE];
  assign sel = state_reg.ctrl[PTS_CB_SEL_LO +: 3];
  assign acc_sum = {1'b0, state_reg.acc} + {1'b0, state_reg.addend};
  assign tick = ts_on & (~fine | acc_sum[32]);
  assign limit = state_reg.ctrl[PTS_CB_DECIMAL] ? PTS_DECIMAL_LIMIT : PTS_BINARY_LIMIT;
  assign sub_sum = {1'b0, state_reg.subsec} + {1'b0, state_reg.step};
  assign wrap = sub_sum > {1'b0, limit};
  assign reached = {state_reg.sec, state_reg.subsec} >= {state_reg.tgt_sec, state_reg.tgt_sub};
  assign fire = state_reg.ctrl[PTS_CB_ARM] & reached;
  assign fire_int = fire & (state_reg.ctrl[PTS_CB_USE_LO +: 2] != PTS_USE_PULSE);
  assign fire_pulse = fire & (state_reg.ctrl[PTS_CB_USE_LO +: 2] != PTS_USE_INT);
  assign pcnt_inc = state_reg.pcnt + 32'h00000001;

  // Frame classification
  always_comb
  begin
    unique case (frame_i.encap)
      PTS_ENC_RAW: enc_ok = state_reg.ctrl[PTS_CB_RAW];
      PTS_ENC_UDP4: enc_ok = state_reg.ctrl[PTS_CB_UDP4];
      PTS_ENC_UDP6: enc_ok = state_reg.ctrl[PTS_CB_UDP6];
      default: enc_ok = 1'b0;
    endcase
    ver_ok = frame_i.version == (state_reg.ctrl[PTS_CB_V2] ? PTS_VER_2 : PTS_VER_1);
    case (sel)
      PTS_SEL_SYNC_FU_DREQ_DRESP: msg_ok = frame_i.msg_type inside {PTS_MSG_SYNC, PTS_MSG_FOLLOW,
                                                                    PTS_MSG_DREQ, PTS_MSG_DRESP};
      PTS_SEL_SYNC: msg_ok = frame_i.msg_type == PTS_MSG_SYNC;
      PTS_SEL_DREQ: msg_ok = frame_i.msg_type == PTS_MSG_DREQ;
      PTS_SEL_ALL: msg_ok = 1'b1;
      PTS_SEL_SYNC_PEER: msg_ok = frame_i.msg_type inside {PTS_MSG_SYNC, PTS_MSG_PDREQ, PTS_MSG_PDRESP};
      PTS_SEL_DREQ_PEER: msg_ok = frame_i.msg_type inside {PTS_MSG_DREQ, PTS_MSG_PDREQ, PTS_MSG_PDRESP};
      PTS_SEL_PEER: msg_ok = frame_i.msg_type inside {PTS_MSG_PDREQ, PTS_MSG_PDRESP};
      default: msg_ok = 1'b0;
    endcase
    ptp_ok = enc_ok & ver_ok;
    addr_ok = ~state_reg.ctrl[PTS_CB_FILTER] | frame_i.dst_match;
  end

  // APB decode
  assign setup = psel_i & ~penable_i;
  assign access = psel_i & penable_i & state_reg.pready;
  assign wr = access & pwrite_i;
  assign rd = access & ~pwrite_i;
  always_comb
  begin
    case (paddr_i)
      PTS_CTRL_OFS, PTS_STEP_OFS, PTS_ADDEND_OFS, PTS_SEC_OFS, PTS_SUBSEC_OFS, PTS_TGT_SEC_OFS,
      PTS_TGT_SUB_OFS, PTS_STATUS_OFS, PTS_CMD_OFS, PTS_WIDTH_OFS, PTS_PERIOD_OFS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    state_next = state_reg;
    state_next.stamp.valid = 1'b0;
    state_next.stamp.drop = 1'b0;

    // Time base
    if (ts_on && fine)
    begin
      state_next.acc = acc_sum[31:0];
    end
    if (tick)
    begin
      if (wrap)
      begin
        state_next.subsec = 32'(sub_sum - ({1'b0, limit} + 33'h000000001));
        state_next.sec = state_reg.sec + 32'h00000001;
        if (state_reg.sec == 32'hFFFFFFFF)
        begin
          state_next.flags[PTS_SB_SECWRAP] = 1'b1;
        end
      end
      else
      begin
        state_next.subsec = sub_sum[31:0];
      end
    end

    // Target comparison
    if (fire)
    begin
      state_next.ctrl[PTS_CB_ARM] = 1'b0;
    end

    // Pulse generator, advancing on update ticks
    if (tick)
    begin
      unique case (state_reg.pg)
        PTS_PG_IDLE:
        begin
          state_next.pulse = 1'b0;
        end
        PTS_PG_HIGH:
        begin
          state_next.pcnt = pcnt_inc;
          if (pcnt_inc >= state_reg.width)
          begin
            state_next.pulse = 1'b0;
            state_next.pg = state_reg.train ? PTS_PG_LOW : PTS_PG_IDLE;
          end
        end
        PTS_PG_LOW:
        begin
          state_next.pcnt = pcnt_inc;
          if (pcnt_inc >= state_reg.period)
          begin
            state_next.pcnt = 32'h00000000;
            state_next.pulse = 1'b1;
            state_next.pg = PTS_PG_HIGH;
          end
        end
      endcase
    end

    // Pending commands taken at the target
    if (fire_pulse && cmd_mode)
    begin
      if (state_reg.pend_stop)
      begin
        state_next.pend_stop = 1'b0;
        state_next.pg = PTS_PG_IDLE;
        state_next.pulse = 1'b0;
        state_next.train = 1'b0;
      end
      if (state_reg.pend_start != PTS_PEND_NONE)
      begin
        state_next.pend_start = PTS_PEND_NONE;
        state_next.pg = PTS_PG_HIGH;
        state_next.pulse = 1'b1;
        state_next.pcnt = 32'h00000000;
        state_next.train = state_reg.pend_start == PTS_PEND_TRAIN;
      end
    end

    // Frame stamping
    if (frame_i.valid && ts_on)
    begin
      if ((frame_i.rx && state_reg.ctrl[PTS_CB_ALLRX]) || (ptp_ok && msg_ok && addr_ok))
      begin
        state_next.stamp.valid = 1'b1;
        state_next.stamp.sec = state_reg.sec;
        state_next.stamp.subsec = state_reg.subsec;
      end
      state_next.stamp.drop = ptp_ok & ~addr_ok;
    end

    // APB slave: ready rises in the access cycle after setup
    state_next.pready = setup;
    if (setup)
    begin
      state_next.pslverr = ~mapped;
      case (paddr_i)
        PTS_CTRL_OFS: state_next.prdata = {16'h0000, state_reg.ctrl};
        PTS_STEP_OFS: state_next.prdata = state_reg.step;
        PTS_ADDEND_OFS: state_next.prdata = state_reg.addend;
        PTS_SEC_OFS: state_next.prdata = state_reg.sec;
        PTS_SUBSEC_OFS: state_next.prdata = state_reg.subsec;
        PTS_TGT_SEC_OFS: state_next.prdata = state_reg.tgt_sec;
        PTS_TGT_SUB_OFS: state_next.prdata = state_reg.tgt_sub;
        PTS_STATUS_OFS: state_next.prdata = {30'h00000000, state_next.flags[PTS_SB_TGTHIT] | fire_int,
                                             state_next.flags[PTS_SB_SECWRAP]};
        PTS_CMD_OFS: state_next.prdata = {26'h0000000, state_reg.pg == PTS_PG_IDLE, state_reg.pulse,
                                          state_reg.train, state_reg.pend_stop, state_reg.pend_start};
        PTS_WIDTH_OFS: state_next.prdata = state_reg.width;
        PTS_PERIOD_OFS: state_next.prdata = state_reg.period;
        default: state_next.prdata = 32'h00000000;
      endcase
    end
    if (access)
    begin
      state_next.pslverr = 1'b0;
    end

    // Status is captured at setup and cleared at access; a flag set at the access edge survives
    if (rd && paddr_i == PTS_STATUS_OFS)
    begin
      state_next.flags = 2'b00;
    end
    if (fire_int)
    begin
      state_next.flags[PTS_SB_TGTHIT] = 1'b1;
    end
    if (tick && wrap && state_reg.sec == 32'hFFFFFFFF)
    begin
      state_next.flags[PTS_SB_SECWRAP] = 1'b1;
    end

    if (wr)
    begin
      case (paddr_i)
        PTS_CTRL_OFS: state_next.ctrl = pwdata_i[PTS_CTRL_W-1:0];
        PTS_STEP_OFS: state_next.step = pwdata_i;
        PTS_ADDEND_OFS: state_next.addend = pwdata_i;
        PTS_SEC_OFS: state_next.sec = pwdata_i;
        PTS_SUBSEC_OFS: state_next.subsec = pwdata_i;
        PTS_TGT_SEC_OFS: state_next.tgt_sec = pwdata_i;
        PTS_TGT_SUB_OFS: state_next.tgt_sub = pwdata_i;
        PTS_WIDTH_OFS: state_next.width = pwdata_i;
        PTS_PERIOD_OFS: state_next.period = pwdata_i;
        PTS_CMD_OFS:
        begin
          if (cmd_mode)
          begin
            unique case (pwdata_i[2:0])
              PTS_CMD_NOOP:
              begin
              end
              PTS_CMD_ONE_PULSE: state_next.pend_start = PTS_PEND_ONE;
              PTS_CMD_BEGIN_TRAIN: state_next.pend_start = PTS_PEND_TRAIN;
              PTS_CMD_ABORT_BEGIN:
              begin
                if (!reached)
                begin
                  state_next.pend_start = PTS_PEND_NONE;
                end
              end
              PTS_CMD_END_AT_TARGET: state_next.pend_stop = 1'b1;
              PTS_CMD_END_IMMEDIATELY:
              begin
                state_next.pg = PTS_PG_IDLE;
                state_next.pulse = 1'b0;
                state_next.train = 1'b0;
              end
              PTS_CMD_ABORT_END:
              begin
                if (!reached)
                begin
                  state_next.pend_stop = 1'b0;
                end
              end
              default:
              begin
              end
            endcase
          end
        end
        default:
        begin
        end
      endcase
    end

    state_next.summary = |state_next.flags;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg <= '0;
      state_reg.ctrl <= PTS_CTRL_RST;
      state_reg.pg <= PTS_PG_IDLE;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign prdata_o = state_reg.prdata;
  assign pready_o = state_reg.pready;
  assign pslverr_o = state_reg.pslverr;
  assign stamp_o = state_reg.stamp;
  assign pulse_output_o = state_reg.pulse;
  assign time_event_summary_o = state_reg.summary;

endmodule

// *** hw/pts_pkg.sv ***
package pts_pkg;

  localparam int PTS_ADDR_W = 8;

  // Register byte offsets
  localparam logic [7:0] PTS_CTRL_OFS = 8'h00;
  localparam logic [7:0] PTS_STEP_OFS = 8'h04;
  localparam logic [7:0] PTS_ADDEND_OFS = 8'h08;
  localparam logic [7:0] PTS_SEC_OFS = 8'h0C;
  localparam logic [7:0] PTS_SUBSEC_OFS = 8'h10;
  localparam logic [7:0] PTS_TGT_SEC_OFS = 8'h14;
  localparam logic [7:0] PTS_TGT_SUB_OFS = 8'h18;
  localparam logic [7:0] PTS_STATUS_OFS = 8'h1C;
  localparam logic [7:0] PTS_CMD_OFS = 8'h20;
  localparam logic [7:0] PTS_WIDTH_OFS = 8'h24;
  localparam logic [7:0] PTS_PERIOD_OFS = 8'h28;

  // Control register fields
  localparam int PTS_CTRL_W = 16;
  localparam int PTS_CB_ENABLE = 0;
  localparam int PTS_CB_FINE = 1;
  localparam int PTS_CB_DECIMAL = 2;
  localparam int PTS_CB_V2 = 3;
  localparam int PTS_CB_FILTER = 4;
  localparam int PTS_CB_UDP4 = 5;
  localparam int PTS_CB_UDP6 = 6;
  localparam int PTS_CB_RAW = 7;
  localparam int PTS_CB_ALLRX = 8;
  localparam int PTS_CB_SEL_LO = 9;
  localparam int PTS_CB_CMDMODE = 12;
  localparam int PTS_CB_USE_LO = 13;
  localparam int PTS_CB_ARM = 15;
  localparam logic [15:0] PTS_CTRL_RST = 16'h0000;

  // Status flag positions
  localparam int PTS_SB_SECWRAP = 0;
  localparam int PTS_SB_TGTHIT = 1;

  // Subsecond wrap limits
  localparam logic [31:0] PTS_DECIMAL_LIMIT = 32'h3BA9C9FF;
  localparam logic [31:0] PTS_BINARY_LIMIT = 32'h7FFFFFFF;

  // Pulse commands
  localparam logic [2:0] PTS_CMD_NOOP = 3'h0;
  localparam logic [2:0] PTS_CMD_ONE_PULSE = 3'h1;
  localparam logic [2:0] PTS_CMD_BEGIN_TRAIN = 3'h2;
  localparam logic [2:0] PTS_CMD_ABORT_BEGIN = 3'h3;
  localparam logic [2:0] PTS_CMD_END_AT_TARGET = 3'h4;
  localparam logic [2:0] PTS_CMD_END_IMMEDIATELY = 3'h5;
  localparam logic [2:0] PTS_CMD_ABORT_END = 3'h6;

  // Target use
  localparam logic [1:0] PTS_USE_INT = 2'h0;
  localparam logic [1:0] PTS_USE_PULSE = 2'h1;
  localparam logic [1:0] PTS_USE_BOTH = 2'h2;

  // Pending start kinds
  localparam logic [1:0] PTS_PEND_NONE = 2'h0;
  localparam logic [1:0] PTS_PEND_ONE = 2'h1;
  localparam logic [1:0] PTS_PEND_TRAIN = 2'h2;

  // Message selection codes
  localparam logic [2:0] PTS_SEL_SYNC_FU_DREQ_DRESP = 3'h0;
  localparam logic [2:0] PTS_SEL_SYNC = 3'h1;
  localparam logic [2:0] PTS_SEL_DREQ = 3'h2;
  localparam logic [2:0] PTS_SEL_ALL = 3'h3;
  localparam logic [2:0] PTS_SEL_SYNC_PEER = 3'h4;
  localparam logic [2:0] PTS_SEL_DREQ_PEER = 3'h5;
  localparam logic [2:0] PTS_SEL_PEER = 3'h6;

  // Message type codes carried in the frame
  localparam logic [3:0] PTS_MSG_SYNC = 4'h0;
  localparam logic [3:0] PTS_MSG_DREQ = 4'h1;
  localparam logic [3:0] PTS_MSG_PDREQ = 4'h2;
  localparam logic [3:0] PTS_MSG_PDRESP = 4'h3;
  localparam logic [3:0] PTS_MSG_FOLLOW = 4'h8;
  localparam logic [3:0] PTS_MSG_DRESP = 4'h9;

  // Protocol version values
  localparam logic [3:0] PTS_VER_1 = 4'h1;
  localparam logic [3:0] PTS_VER_2 = 4'h2;

  typedef enum logic [1:0] {
    PTS_ENC_RAW = 2'h0,
    PTS_ENC_UDP4 = 2'h1,
    PTS_ENC_UDP6 = 2'h2,
    PTS_ENC_OTHER = 2'h3
  } pts_encap_t;

  typedef enum logic [2:0] {
    PTS_PG_IDLE = 3'b001,
    PTS_PG_HIGH = 3'b010,
    PTS_PG_LOW = 3'b100
  } pts_pg_state_t;

  typedef struct packed {
    logic valid;
    logic rx;
    pts_encap_t encap;
    logic [3:0] msg_type;
    logic [3:0] version;
    logic dst_match;
  } pts_frame_t;

  typedef struct packed {
    logic valid;
    logic drop;
    logic [31:0] sec;
    logic [31:0] subsec;
  } pts_stamp_t;

endpackage

// *** verification/pts_time_core_chk.sv ***
`timescale 1ns/1ps
module pts_time_core_chk
  import pts_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [PTS_ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire pts_frame_t frame_i,
  input wire pts_stamp_t stamp_o,
  input wire logic pulse_output_o,
  input wire logic time_event_summary_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////
  sequence s_setup;
    psel_i && !penable_i;
  endsequence
  sequence s_access;
    psel_i && penable_i && pready_o;
  endsequence
  ////////////////////////////////////////////////////////////////////////
  a_ready_after_setup: assert property (s_setup |=> pready_o) else $error("no ready after setup");
  a_ready_one_cycle: assert property (s_access |=> !pready_o) else $error("ready held too long");
  a_ready_has_cause: assert property ($rose(pready_o) |-> $past(psel_i && !penable_i))
    else $error("ready without setup");
  a_idle_quiet: assert property (!psel_i |=> !pready_o && !pslverr_o) else $error("answer while idle");
  a_err_read_zero: assert property (pready_o && pslverr_o && !pwrite_i |-> prdata_o == 32'h0)
    else $error("refused read returned data");
  a_stamp_has_frame: assert property (stamp_o.valid || stamp_o.drop |-> $past(frame_i.valid))
    else $error("stamp without frame");
  a_drop_unmatched: assert property (stamp_o.drop |-> !$past(frame_i.dst_match))
    else $error("matching frame dropped");
  a_drop_encap_known: assert property (stamp_o.drop |-> $past(frame_i.encap) != PTS_ENC_OTHER)
    else $error("unknown encapsulation handled");
  a_stamp_hold: assert property (!stamp_o.valid |-> $stable(stamp_o.sec) && $stable(stamp_o.subsec))
    else $error("stamp time moved");
  a_summary_clear: assert property ($fell(time_event_summary_o) |->
    $past(pready_o && !pwrite_i && paddr_i == PTS_STATUS_OFS))
    else $error("summary cleared without status read");
endmodule
bind pts_time_core pts_time_core_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .frame_i(frame_i),
  .stamp_o(stamp_o), .pulse_output_o(pulse_output_o), .time_event_summary_o(time_event_summary_o));

// *** verification/pts_time_core_tb_top.sv ***
`timescale 1ns/1ps
module pts_time_core_tb_top
  import pts_pkg::*;
;
  logic clk_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd, ctl;
  logic pready_o, pslverr_o, pulse_output_o, time_event_summary_o, err;
  pts_frame_t frame_i = '0;
  pts_stamp_t stamp_o;
  int fails = 0, total_checks = 0, cyc = 0, c0, hi, lo, step;
  longint m_sec, m_sub, acc;
  pts_time_core u_pts_time_core (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .frame_i(frame_i), .stamp_o(stamp_o), .pulse_output_o(pulse_output_o),
    .time_event_summary_o(time_event_summary_o));
  always #2 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fails++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer; c0 keeps the cycle at which it took effect
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1;
    penable_i <= 0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    c0 = cyc;
    psel_i <= 0;
    penable_i <= 0;
  endtask
  // Model of the time counters over n clock edges
  task automatic adv(input int n, input logic dec, input logic fine, input longint add);
    longint lim;
    lim = dec ? 64'h3BA9C9FF : 64'h7FFFFFFF;
    repeat (n)
    begin
      acc += add;
      if (!fine || acc >= 64'h100000000)
      begin
        acc &= 64'hFFFFFFFF;
        m_sub += step;
        if (m_sub > lim)
        begin
          m_sub -= lim + 1;
          m_sec = (m_sec + 1) & 64'hFFFFFFFF;
        end
      end
    end
  endtask
  // Runs the counters from a set time for a while, then compares
  task automatic run(input longint s, input longint sub, input logic dec, input logic fine, input int w);
    m_sec = s;
    m_sub = sub;
    step = $urandom_range(3, 15);
    apb(1, PTS_STEP_OFS, step);
    apb(1, PTS_ADDEND_OFS, 32'h80000000);
    apb(1, PTS_SEC_OFS, s[31:0]);
    apb(1, PTS_SUBSEC_OFS, sub[31:0]);
    ctl = (1 << PTS_CB_ENABLE) | (fine << PTS_CB_FINE) | (dec << PTS_CB_DECIMAL);
    apb(1, PTS_CTRL_OFS, ctl);
    hi = c0;
    repeat (w) @(posedge clk_i);
    apb(1, PTS_CTRL_OFS, ctl & ~32'h1);
    adv(c0 - hi, dec, fine, fine ? 64'h80000000 : 0);
    repeat (5) @(posedge clk_i);
    apb(0, PTS_SUBSEC_OFS, 0);
    chk(rd, m_sub[31:0]);
    apb(0, PTS_SEC_OFS, 0);
    chk(rd, m_sec[31:0]);
  endtask
  function automatic logic sel_ok(input logic [2:0] s, input logic [3:0] m);
    case (s)
      3'h0: return m inside {4'h0, 4'h8, 4'h1, 4'h9};
      3'h1: return m == 4'h0;
      3'h2: return m == 4'h1;
      3'h3: return 1'b1;
      3'h4: return m inside {4'h0, 4'h2, 4'h3};
      3'h5: return m inside {4'h1, 4'h2, 4'h3};
      default: return m inside {4'h2, 4'h3};
    endcase
  endfunction
  task automatic pulse_len();
    int n;
    n = 0;
    while (pulse_output_o !== 1'b1 && n < 300)
    begin
      @(posedge clk_i);
      n++;
    end
    hi = 0;
    lo = 0;
    while (pulse_output_o === 1'b1 && hi < 300)
    begin
      @(posedge clk_i);
      hi++;
    end
    while (pulse_output_o !== 1'b1 && lo < 20)
    begin
      @(posedge clk_i);
      lo++;
    end
  endtask
  // Sets time 0 (target stays at subsecond 60 from before), sends the commands, then starts
  task automatic arm_run(input logic [1:0] use_sel, input logic [2:0] c1, input logic [2:0] c2);
    ctl = (1 << PTS_CB_CMDMODE) | (use_sel << PTS_CB_USE_LO);
    apb(1, PTS_CTRL_OFS, ctl);
    apb(1, PTS_SEC_OFS, 0);
    apb(1, PTS_SUBSEC_OFS, 0);
    apb(1, PTS_CMD_OFS, c1);
    apb(1, PTS_CMD_OFS, c2);
    apb(1, PTS_CTRL_OFS, ctl | 32'h1 | (1 << PTS_CB_ARM));
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    pts_frame_t f;
    logic ok, pass;
    void'($urandom(83073));
    repeat (20) @(posedge clk_i);
    rst_i <= 0;
    apb(0, PTS_CTRL_OFS, 0);
    chk(rd, 32'h0);
    apb(0, 8'h40, 0);
    chk({err, rd[30:0]}, 32'h80000000);
    acc = 0;
    run(5, 64'h3BA9C9FF - 30, 1, 0, 12);
    run(64'hFFFFFFFF, 64'h7FFFFFFF - 25, 0, 0, 9);
    chk(time_event_summary_o, 1);
    apb(0, PTS_STATUS_OFS, 0);
    chk(rd & 32'h1, 32'h1);
    apb(0, PTS_STATUS_OFS, 0);
    chk({time_event_summary_o, rd[30:0]}, 32'h0);
    run(0, 64'h3BA9C9FF - 100, 1, 1, 30);
    // Frames with frozen time so the stamp value is known
    apb(1, PTS_STEP_OFS, 0);
    apb(1, PTS_SEC_OFS, 32'h00001234);
    for (int b = 0; b < 4; b++)
    begin
      ctl = $urandom & 32'h00000FF9;
      ctl[PTS_CB_ENABLE] = (b != 0);
      ctl[PTS_CB_ALLRX] = (b == 3);
      if (ctl[11:9] == 3'h7)
        ctl[11:9] = 3'h3;
      apb(1, PTS_CTRL_OFS, ctl);
      repeat (30)
      begin
        f = pts_frame_t'($urandom);
        f.valid = 1;
        f.rx = 1;
        f.version = $urandom_range(1, 2);
        f.msg_type = (b == 3) ? 4'($urandom) : (f.msg_type[1:0] | {f.msg_type[3], 3'h0});
        if (b == 3)
        begin
          f.encap = PTS_ENC_RAW;
          f.version = ctl[PTS_CB_V2] ? 4'h2 : 4'h1;
          f.dst_match = 1;
          ctl[PTS_CB_RAW] = 1;
          apb(1, PTS_CTRL_OFS, ctl);
        end
        pass = ctl[0] && f.version == (ctl[PTS_CB_V2] ? 4'h2 : 4'h1)
          && ((f.encap == PTS_ENC_RAW && ctl[PTS_CB_RAW]) || (f.encap == PTS_ENC_UDP4 && ctl[PTS_CB_UDP4])
          || (f.encap == PTS_ENC_UDP6 && ctl[PTS_CB_UDP6]));
        ok = pass && (!ctl[PTS_CB_FILTER] || f.dst_match) && (ctl[PTS_CB_ALLRX] || sel_ok(ctl[11:9], f.msg_type));
        @(posedge clk_i);
        frame_i <= f;
        @(posedge clk_i);
        frame_i.valid <= 0;
        #1;
        chk(stamp_o.valid, ok);
        chk(stamp_o.drop, pass && ctl[PTS_CB_FILTER] && !f.dst_match);
        if (ok)
        begin
          chk(stamp_o.sec, 32'h00001234);
          chk(stamp_o.subsec, m_sub[31:0]);
        end
      end
    end
    // Pulse generator
    apb(1, PTS_STEP_OFS, 1);
    apb(1, PTS_WIDTH_OFS, 3);
    apb(1, PTS_PERIOD_OFS, 8);
    apb(1, PTS_TGT_SEC_OFS, 0);
    apb(1, PTS_TGT_SUB_OFS, 60);
    apb(1, PTS_SEC_OFS, 0);
    apb(1, PTS_SUBSEC_OFS, 0);
    apb(1, PTS_CTRL_OFS, 0);
    apb(1, PTS_CMD_OFS, PTS_CMD_ONE_PULSE);
    apb(0, PTS_CMD_OFS, 0);
    chk(rd[2:0], 0);
    ctl = 1 << PTS_CB_CMDMODE;
    apb(1, PTS_CTRL_OFS, ctl);
    apb(1, PTS_CMD_OFS, PTS_CMD_ONE_PULSE);
    apb(1, PTS_CMD_OFS, PTS_CMD_BEGIN_TRAIN);
    apb(1, PTS_CMD_OFS, PTS_CMD_END_AT_TARGET);
    apb(0, PTS_CMD_OFS, 0);
    chk(rd[2:0], {1'b1, PTS_PEND_TRAIN});
    apb(1, PTS_CMD_OFS, PTS_CMD_ABORT_END);
    apb(1, PTS_CMD_OFS, PTS_CMD_ABORT_BEGIN);
    apb(1, PTS_CMD_OFS, PTS_CMD_NOOP);
    apb(0, PTS_CMD_OFS, 0);
    chk(rd[2:0], 0);
    apb(1, PTS_CMD_OFS, PTS_CMD_BEGIN_TRAIN);
    apb(1, PTS_SUBSEC_OFS, 100);
    apb(1, PTS_CMD_OFS, PTS_CMD_ABORT_BEGIN);
    apb(0, PTS_CMD_OFS, 0);
    chk(rd[2:0], {1'b0, PTS_PEND_TRAIN});
    arm_run(PTS_USE_PULSE, PTS_CMD_NOOP, PTS_CMD_ONE_PULSE);
    pulse_len();
    chk(hi, 3);
    apb(0, PTS_STATUS_OFS, 0);
    chk(rd[1:0], 0);
    arm_run(PTS_USE_BOTH, PTS_CMD_END_AT_TARGET, PTS_CMD_ABORT_END);
    apb(1, PTS_CMD_OFS, PTS_CMD_BEGIN_TRAIN);
    pulse_len();
    chk(hi, 3);
    chk(lo, 5);
    pulse_len();
    chk(hi, 3);
    apb(1, PTS_CMD_OFS, PTS_CMD_END_IMMEDIATELY);
    pulse_len();
    chk(hi, 0);
    apb(0, PTS_STATUS_OFS, 0);
    chk(rd[1:0], 2'b10);
    arm_run(PTS_USE_INT, PTS_CMD_NOOP, PTS_CMD_ONE_PULSE);
    pulse_len();
    chk(hi, 0);
    apb(0, PTS_STATUS_OFS, 0);
    chk(rd[1:0], 2'b10);
    report_and_stop();
  end
endmodule
